// *** src/cfgld_top.sv ***
`timescale 1ns/10ps
module cfgld_top (
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      config_clock_pin_in,
  output logic                           config_clock_pin_out,
  output logic                           config_clock_pin_oe,
  input  wire logic                      data_in,
  input  wire logic                      program_n,
  input  wire logic [2:0]                mode_select_inputs,
  input  wire logic                      done_in,
  output logic                           done_out,
  output logic                           done_oe,
  output logic                           init_out,
  output logic                           init_oe,
  input  wire logic                      done_wait_option,
  input  wire logic                      readback_clk_sel,
  output logic                           readback_clk_en,
  output logic                           logic_init_hold,
  output logic                           outputs_enable,
  output logic [2:0]                     config_mode,
  input  wire logic [cfgld_pkg::ADDR_W-1:0] mem_rd_addr,
  output logic [cfgld_pkg::WORD_W-1:0]   mem_rd_data
);
  import cfgld_pkg::*;

  typedef struct packed {
    logic                             prog_s1;
    logic                             prog_s2;
    logic [2:0]                       mode_s1;
    logic [2:0]                       mode_s2;
    logic                             done_s1;
    logic                             done_s2;
    logic                             wait_s1;
    logic                             wait_s2;
    logic                             rbsel_s1;
    logic                             rbsel_s2;
    logic                             tog_s1;
    logic                             tog_s2;
    logic                             tog_s3;
    cfgld_state_t                     state;
    logic [ADDR_W-1:0]                clr_addr;
    logic [ADDR_W-1:0]                wr_addr;
    logic [2:0]                       mode;
    logic [2:0]                       div_cnt;
    logic                             clk_out;
    logic                             clk_oe;
    logic                             done_oe;
    logic                             init_oe;
    logic                             rb_en;
    logic                             load_en;
    logic                             init_hold;
    logic                             out_en;
    logic [WORD_W-1:0]                rd_data;
    logic [CFG_WORDS-1:0][WORD_W-1:0] mem;
  } cfgld_st_t;

  cfgld_st_t   r;
  cfgld_st_t   next_r;
  cfgld_word_t link_word;
  logic        prog_act;
  logic        word_stb;

  assign prog_act = ~r.prog_s2;
  assign word_stb = r.tog_s2 ^ r.tog_s3;

  cfgld_link u_link (
    .config_clock_pin_in (config_clock_pin_in),
    .load_en             (r.load_en),
    .data_in             (data_in),
    .link_word           (link_word)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_r          = r;
    next_r.prog_s1  = program_n;
    next_r.prog_s2  = r.prog_s1;
    next_r.mode_s1  = mode_select_inputs;
    next_r.mode_s2  = r.mode_s1;
    next_r.done_s1  = done_in;
    next_r.done_s2  = r.done_s1;
    next_r.wait_s1  = done_wait_option;
    next_r.wait_s2  = r.wait_s1;
    next_r.rbsel_s1 = readback_clk_sel;
    next_r.rbsel_s2 = r.rbsel_s1;
    next_r.tog_s1   = link_word.toggle;
    next_r.tog_s2   = r.tog_s1;
    next_r.tog_s3   = r.tog_s2;
    next_r.rd_data  = r.mem[mem_rd_addr];
    if (prog_act && r.state != ST_CLEAR) begin
      next_r.state    = ST_CLEAR; // [RULE11]
      next_r.clr_addr = '0;
    end else begin
      unique case (r.state)
        ST_CLEAR, ST_CLEAR_LAST: begin
          next_r.mem[r.clr_addr] = '0; // [RULE6]
          next_r.clr_addr        = r.clr_addr + 4'h1;
          if (r.clr_addr == ADDR_LAST) begin
            if (r.state == ST_CLEAR_LAST) begin
              next_r.state = ST_WAIT; // [RULE9]
            end else if (!prog_act) begin
              next_r.state = ST_CLEAR_LAST; // [RULE8]
            end
          end
        end
        ST_WAIT: begin
          next_r.mode    = r.mode_s2; // [RULE10]
          next_r.wr_addr = '0;
          next_r.div_cnt = '0;
          next_r.clk_out = 1'b0;
          next_r.state   = ST_LOAD;
        end
        ST_LOAD: begin
          if (r.div_cnt == DIV_LAST) begin
            next_r.div_cnt = '0;
            next_r.clk_out = ~r.clk_out;
          end else begin
            next_r.div_cnt = r.div_cnt + 3'h1;
          end
          if (word_stb) begin
            next_r.mem[r.wr_addr] = link_word.word;
            next_r.wr_addr        = r.wr_addr + 4'h1;
            if (r.wr_addr == ADDR_LAST) begin
              next_r.state = ST_STARTUP;
            end
          end
        end
        ST_STARTUP: begin
          if (!(r.wait_s2 && !r.done_s2)) begin
            next_r.state = ST_RUN; // [RULE5]
          end
        end
        ST_RUN: begin
        end
        default: begin
          next_r.state    = ST_CLEAR;
          next_r.clr_addr = '0;
        end
      endcase
    end
    next_r.clk_oe    = (next_r.state == ST_LOAD) && cfgld_drives_clk(next_r.mode); // [RULE1] [RULE2]
    next_r.done_oe   = next_r.state inside {ST_CLEAR, ST_CLEAR_LAST, ST_WAIT, ST_LOAD}; // [RULE4]
    next_r.init_oe   = next_r.state inside {ST_CLEAR, ST_CLEAR_LAST}; // [RULE9]
    next_r.init_hold = next_r.state != ST_RUN; // [RULE5]
    next_r.out_en    = next_r.state == ST_RUN;
    next_r.load_en   = next_r.state == ST_LOAD;
    next_r.rb_en     = (next_r.state == ST_RUN) && r.rbsel_s2; // [RULE3]
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      r           <= '0;
      r.prog_s1   <= 1'b1;
      r.prog_s2   <= 1'b1;
      r.state     <= ST_CLEAR;
      r.mode      <= MODE_RST;
      r.done_oe   <= 1'b1;
      r.init_oe   <= 1'b1;
      r.init_hold <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign config_clock_pin_out = r.clk_out;
  assign config_clock_pin_oe  = r.clk_oe;
  assign done_out             = 1'b0;
  assign done_oe              = r.done_oe;
  assign init_out             = 1'b0;
  assign init_oe              = r.init_oe;
  assign readback_clk_en      = r.rb_en;
  assign logic_init_hold      = r.init_hold;
  assign outputs_enable       = r.out_en;
  assign config_mode          = r.mode;
  assign mem_rd_data          = r.rd_data;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  clk_drive_a: assert property ((r.state == ST_LOAD && r.clk_oe)
    |-> ##[1:4] ($changed(r.clk_out) || r.state != ST_LOAD)) // [RULE1]
    else $error("config clock not toggling in master load");
  clk_input_a: assert property (r.clk_oe |-> (r.state == ST_LOAD && cfgld_drives_clk(r.mode))) // [RULE2]
    else $error("config clock driven in slave mode");
  readback_gate_a: assert property (r.rb_en |-> (r.state == ST_RUN && $past(r.rbsel_s2))) // [RULE3]
    else $error("readback clock enabled before run");
  done_flag_a: assert property ($rose(r.state == ST_STARTUP) |-> !r.done_oe && $past(r.done_oe)) // [RULE4]
    else $error("done not released at completion");
  done_hold_a: assert property ((r.state == ST_STARTUP && r.wait_s2 && !r.done_s2 && !prog_act)
    |=> r.state == ST_STARTUP && r.init_hold && !r.out_en) // [RULE5]
    else $error("start-up not held by low done");
  mem_clear_a: assert property ($rose(r.state == ST_WAIT) |-> r.mem == '0) // [RULE6]
    else $error("memory not clear at wait");
  extra_pass_a: assert property ($rose(r.state == ST_CLEAR_LAST)
    |-> r.clr_addr == '0 && $past(r.clr_addr) == ADDR_LAST && !$past(prog_act)) // [RULE8]
    else $error("extra clear pass not aligned");
  wait_entry_a: assert property ((r.state == ST_CLEAR_LAST && r.clr_addr == ADDR_LAST && !prog_act)
    |=> r.state == ST_WAIT && !r.init_oe) // [RULE9]
    else $error("init not released after extra pass");
  mode_sample_a: assert property ($rose(r.state == ST_LOAD) |-> r.mode == $past(r.mode_s2)) // [RULE10]
    else $error("mode not sampled at wait");
  restart_a: assert property ((prog_act && r.state != ST_CLEAR)
    |=> r.state == ST_CLEAR && r.clr_addr == '0 && r.init_oe) // [RULE11]
    else $error("program did not restart clear");

  reach_run_c: cover property (r.state == ST_STARTUP ##1 r.state == ST_RUN);
  done_stall_c: cover property ((r.state == ST_STARTUP && r.wait_s2 && !r.done_s2) [*3]);
  load_abort_c: cover property (r.state == ST_LOAD && prog_act);
  master_clk_c: cover property (r.clk_oe && $rose(r.clk_out));

endmodule

// *** src/cfgld_pkg.sv ***
//
// Behaviour
// [RULE1] In master and asynchronous peripheral modes the device drives the configuration clock.
// [RULE2] In slave and synchronous peripheral modes the configuration clock comes from outside.
// [RULE3] After configuration the configuration clock may be selected as readback clock.
// [RULE4] The done pin is an output showing the whole configuration has finished.
// [RULE5] Optionally, a low done pin held outside delays logic init and output enable.
// [RULE6] While the active-low program input is asserted, configuration memory is cleared.
// [RULE7] An outside party asserts then releases program to start a new configuration.
// [RULE8] On program release, finish the current clear pass, then one more full pass.
// [RULE9] After the extra pass, enter waiting and release the clear-finished indication.
// [RULE10] When clear-finished goes high, sample the three mode-select inputs.
// [RULE11] Program asserted again anywhere abandons configuration and restarts the clear.
package cfgld_pkg;

  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int         CFG_WORDS     = 16;
  localparam int         WORD_W        = 8;
  localparam int         ADDR_W        = 4;
  localparam logic [3:0] ADDR_LAST     = 4'hf;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam int         SYS_CLK_NS    = 10;
  localparam int         MCLK_HALF_NS  = 40;
  localparam int         MCLK_HALF_CYC = (MCLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [2:0] DIV_LAST      = 3'(MCLK_HALF_CYC - 1);

  // ----------------------------------------------------------------
  // Mode-select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_MSER   = 3'h0;
  localparam logic [2:0] MODE_MPAR_U = 3'h4;
  localparam logic [2:0] MODE_MPAR_D = 3'h6;
  localparam logic [2:0] MODE_APER   = 3'h5;
  localparam logic [2:0] MODE_SPER   = 3'h3;
  localparam logic [2:0] MODE_SSER   = 3'h7;
  localparam logic [2:0] MODE_RST    = 3'h7;

  typedef enum logic [2:0] {
    ST_CLEAR      = 3'h0,
    ST_CLEAR_LAST = 3'h1,
    ST_WAIT       = 3'h2,
    ST_LOAD       = 3'h3,
    ST_STARTUP    = 3'h4,
    ST_RUN        = 3'h5
  } cfgld_state_t;

  // Drive side of a two-way or open-drain pin
  typedef struct packed {
    logic out;
    logic oe;
  } cfgld_pin_t;

  // Word handed from the link domain
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic              toggle;
  } cfgld_word_t;

  function automatic logic cfgld_drives_clk(input logic [2:0] mode);
    return (mode == MODE_MSER) || (mode == MODE_MPAR_U) || (mode == MODE_MPAR_D) || (mode == MODE_APER);
  endfunction

endpackage

// *** src/cfgld_link.sv ***
`timescale 1ns/10ps
module cfgld_link (
  input  wire logic                config_clock_pin_in,
  input  wire logic                load_en,
  input  wire logic                data_in,
  output cfgld_pkg::cfgld_word_t   link_word
);
  import cfgld_pkg::*;

  typedef struct packed {
    logic              en_s1;
    logic              en_s2;
    logic [WORD_W-1:0] shreg;
    logic [2:0]        bitcnt;
    logic [WORD_W-1:0] word;
    logic              toggle;
  } cfgld_link_st_t;

  cfgld_link_st_t r;
  cfgld_link_st_t next_r;

  // ----------------------------------------------------------------
  // Serial shift, MSB first, one bit per configuration clock rise
  // ----------------------------------------------------------------
  always_comb begin
    next_r       = r;
    next_r.en_s1 = 1'b1;
    next_r.en_s2 = r.en_s1;
    if (r.en_s2) begin
      next_r.shreg  = {r.shreg[WORD_W-2:0], data_in};
      next_r.bitcnt = r.bitcnt + 3'h1;
      if (r.bitcnt == BIT_LAST) begin
        next_r.word   = {r.shreg[WORD_W-2:0], data_in};
        next_r.toggle = ~r.toggle;
      end
    end
  end

  // Frame state clears at once, as the link clock may already be stopped;
  // the release passes two link edges before the first bit is taken
  always_ff @(posedge config_clock_pin_in or negedge load_en) begin
    if (!load_en) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign link_word = '{word: r.word, toggle: r.toggle};

endmodule

// *** bench/cfgld_host.sv ***
`timescale 1ns/10ps
module cfgld_host (
  input  wire logic       dev_clk,
  input  wire logic       dev_clk_oe,
  input  wire logic       run,
  input  wire logic       program_n,
  input  wire logic       hold_done,
  input  wire logic       done_oe,
  input  wire logic [7:0] base,
  output logic            pin_clk,
  output logic            data,
  output logic            done_pin
);
  logic       host_clk;
  logic [7:0] nbit;
  logic [7:0] pos;
  logic [7:0] word;

  // ----------------------------------------------------------------
  // Clock of the far side, still outside frames
  // ----------------------------------------------------------------
  initial begin
    host_clk = 1'b0;
    #4;
    forever begin
      host_clk = run ? ~host_clk : 1'b0;
      #24;
    end
  end

  assign pin_clk = dev_clk_oe ? dev_clk : host_clk;

  // ----------------------------------------------------------------
  // Serial data, next bit put out on the falling edge
  // ----------------------------------------------------------------
  always @(negedge pin_clk or negedge program_n) begin
    if (!program_n)
      nbit <= 8'h00;
    else
      nbit <= nbit + 8'h01;
  end

  // The device lets two link edges pass before it shifts: two lead-in bits
  assign pos  = nbit - 8'h02;
  assign word = base ^ 8'(pos[6:3] * 29);
  // After the last word the line toggles so no stale bit is seen
  assign data = pos[7] ? pos[0] : word[3'h7 - pos[2:0]];

  // Open-drain done wire with pull-up; the host may hold it low
  assign done_pin = (done_oe | hold_done) ? 1'b0 : 1'b1;
endmodule

// *** bench/cfgld_top_tb.sv ***
`timescale 1ns/10ps
module cfgld_top_tb;
  import cfgld_pkg::*;
  logic       sys_clk, sys_rst, program_n, run, hold_done, done_wait_option, readback_clk_sel;
  logic       config_clock_pin_in, config_clock_pin_out, config_clock_pin_oe, data_in, done_in;
  logic       done_oe, init_oe, readback_clk_en, logic_init_hold, outputs_enable;
  logic [2:0] mode_select_inputs, config_mode;
  logic [3:0] mem_rd_addr;
  logic [7:0] mem_rd_data, base;
  int         failures = 0, n_tests = 0, cyc = 0, seed = 32'h3f04, k;
  logic [2:0] modes [6] = '{3'h0, 3'h4, 3'h6, 3'h5, 3'h3, 3'h7};

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  cfgld_top u_cfgld_top (.sys_clk, .sys_rst, .config_clock_pin_in, .config_clock_pin_out, .config_clock_pin_oe,
    .data_in, .program_n, .mode_select_inputs, .done_in, .done_out(), .done_oe, .init_out(), .init_oe,
    .done_wait_option, .readback_clk_sel, .readback_clk_en, .logic_init_hold, .outputs_enable, .config_mode,
    .mem_rd_addr, .mem_rd_data);

  cfgld_host u_cfgld_host (.dev_clk(config_clock_pin_out), .dev_clk_oe(config_clock_pin_oe), .run, .program_n,
    .hold_done, .done_oe, .base, .pin_clk(config_clock_pin_in), .data(data_in), .done_pin(done_in));

  // ----------------------------------------------------------------
  // Expectations and compares
  // ----------------------------------------------------------------
  function automatic logic drives(input logic [2:0] m);
    return m == 3'h0 || m == 3'h4 || m == 3'h6 || m == 3'h5;
  endfunction

  task automatic check_bit(input string what, input logic exp, input logic seen);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input int a);
    mem_rd_addr <= 4'(a);
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // One configuration cycle, optionally aborted during the load
  // ----------------------------------------------------------------
  task automatic load(input logic [2:0] m, input logic hold, input logic abort);
    int t;
    @(posedge sys_clk);
    mode_select_inputs <= m;
    base <= 8'($random(seed));
    hold_done <= hold;
    done_wait_option <= hold;
    readback_clk_sel <= 1'($random(seed));
    program_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check_bit("init_oe", 1'b1, init_oe);
    check_bit("done_oe", 1'b1, done_oe);
    program_n <= 1'b1;
    t = 0;
    do begin
      @(posedge sys_clk);
      t++;
    end while (init_oe !== 1'b0 && t < 100);
    check_bit("clear_span", 1'b1, t >= 18 && t <= 40);
    for (int i = 0; i < 16; i++) begin
      rd(i);
      check_byte("cleared", 8'h00, mem_rd_data);
    end
    check_byte("mode", {5'h00, m}, {5'h00, config_mode});
    check_bit("clk_oe", drives(m), config_clock_pin_oe);
    run <= ~drives(m);
    if (abort) begin
      repeat (60) @(posedge sys_clk);
      program_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check_bit("abort_init", 1'b1, init_oe);
      check_bit("abort_clk_oe", 1'b0, config_clock_pin_oe);
      run <= 1'b0;
      return;
    end
    t = 0;
    while (done_oe !== 1'b0 && t < 3000) begin
      @(posedge sys_clk);
      t++;
    end
    run <= 1'b0;
    check_bit("done_low", 1'b0, done_oe);
    if (hold) begin
      repeat (20) @(posedge sys_clk);
      check_bit("held_out_en", 1'b0, outputs_enable);
      check_bit("held_init", 1'b1, logic_init_hold);
      hold_done <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
    check_bit("out_en", 1'b1, outputs_enable);
    check_bit("init_hold", 1'b0, logic_init_hold);
    check_bit("rb_en", readback_clk_sel, readback_clk_en);
    for (int i = 0; i < 16; i++) begin
      rd(i);
      check_byte("word", base ^ 8'(i * 29), mem_rd_data);
    end
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      print_verdict;
    end
  end

  initial begin
    sys_rst = 1'b1;
    program_n = 1'b0;
    run = 1'b1;
    hold_done = 1'b0;
    done_wait_option = 1'b0;
    readback_clk_sel = 1'b0;
    mode_select_inputs = 3'h7;
    mem_rd_addr = 4'h0;
    base = 8'h00;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    run <= 1'b0;
    load(3'h7, 1'b1, 1'b0);
    load(3'h7, 1'b0, 1'b1);
    for (k = 0; k < 6; k++)
      load(modes[k], 1'($random(seed)), 1'b0);
    load(3'h3, 1'b0, 1'b1);
    load(3'h0, 1'b1, 1'b0);
    print_verdict;
  end
endmodule
